// File: psrt_curve.sv
// Package for the protection stage release timer, and the inverse-time curve evaluator.
// Assumes the curve inputs stay steady for a cycle; the result is purely combinational.
`timescale 1ns/1ns

package psrt_pkg;
  // Clock and time base.
  localparam int CLK_PERIOD_NS     = 20;
  localparam int TICK_PERIOD_NS    = 1000000;
  localparam int TICK_CYCLES       = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int MS_PER_S          = 1000;
  // Release delay: 0.005 s steps, 0.06 s by default.
  localparam int RELEASE_STEP_MS   = 5;
  localparam int RELEASE_DEF_STEPS = 12;
  // Mechanical grading curve constants 0.339 and 0.236, in thousandths.
  localparam int MG_A_MILLI        = 339;
  localparam int MG_B_MILLI        = 236;
  // Logarithmic curve constants 5.8 s and 1.35 s, in milliseconds.
  localparam int LG_A_MS           = 5800;
  localparam int LG_B_MS           = 1350;
  // Natural log of two in Q16.
  localparam int LN2_Q16           = 45426;
  // Settings reset values.
  localparam logic DEF_DELAYED     = 1'b1;
  localparam logic DEF_OP_RESET    = 1'b1;
  localparam logic DEF_CONTINUE    = 1'b0;

  typedef enum logic {CURVE_MECH = 1'b0, CURVE_LOG = 1'b1} psrt_curve_t;

  typedef enum logic [2:0]
  {
    FORCE_NORMAL  = 3'h1,
    FORCE_START   = 3'h2,
    FORCE_TRIP    = 3'h3,
    FORCE_BLOCKED = 3'h4
  } psrt_force_t;

  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_RUN = 2'h1, ST_HOLD = 2'h3} psrt_state_t;

  typedef struct packed
  {
    logic        delayed_release;
    logic        op_reset_after_release;
    logic        continue_timing;
    logic [15:0] release_steps;
  } psrt_cfg_t;

  typedef struct packed
  {
    logic start;
    logic trip;
    logic blocked;
  } psrt_out_t;
endpackage

////////////////////////////////////////////////////////////////////////////////

module psrt_curve #(
  parameter int W  = 16,
  parameter int TW = 24
) (
  input  wire logic [W-1:0]        measured_max_current,
  input  wire logic [W-1:0]        pickup_setting,
  input  wire logic [W-1:0]        time_dial_milli,
  input  wire psrt_pkg::psrt_curve_t sel,
  output logic      [TW-1:0]       delay_ms
);
  import psrt_pkg::*;

  // Integer part is the leading-one position, fraction is the next eight bits.
  // The linear mantissa costs up to about 6 percent of log error near mid-octave.
  function automatic logic [15:0] log2_q8(input logic [39:0] v);
    logic [5:0]  msb;
    logic [39:0] norm;
    msb = 6'h00;
    for (int i = 0; i < 40; i++)
      if (v[i])
        msb = 6'(i);
    norm = v << (6'd39 - msb);
    return {2'b00, msb, norm[38:31]};
  endfunction

  logic        [47:0] ratio_q16;
  logic        [47:0] prod;
  logic        [47:0] den;
  logic        [47:0] quot;
  logic signed [39:0] ln_q8;
  logic signed [39:0] lg_ms;
  logic        [47:0] mg_ms;

  always_comb
  begin
    // Mechanical grading: k / (0.339 - 0.236 * Iset / Im).
    ratio_q16 = (measured_max_current == '0) ? 48'hffff_ffff
              : 48'({pickup_setting, 16'h0000}) / 48'(measured_max_current);
    prod      = 48'(MG_B_MILLI) * ratio_q16;
    den       = (48'(MG_A_MILLI) << 16) - prod;
    quot      = (prod >= (48'(MG_A_MILLI) << 16)) ? '1
              : (48'(time_dial_milli) * 48'(MS_PER_S * 65536)) / den;
    mg_ms     = (quot > 48'({TW{1'b1}})) ? 48'({TW{1'b1}}) : quot;
    // Logarithmic: 5.8 - 1.35 * ln(Im / (k * Iset)), floored at zero.
    ln_q8     = $signed({24'h000000, log2_q8(40'(measured_max_current) * 40'(MS_PER_S))})
              - $signed({24'h000000, log2_q8(40'(time_dial_milli) * 40'(pickup_setting))});
    ln_q8     = (ln_q8 * $signed(40'(LN2_Q16))) >>> 16;
    lg_ms     = $signed(40'(LG_A_MS)) - (($signed(40'(LG_B_MS)) * ln_q8) >>> 8);
    if (sel == CURVE_LOG)
      delay_ms = (lg_ms < 0) ? '0 : TW'(lg_ms);
    else
      delay_ms = TW'(mg_ms);
  end
endmodule

// File: psrt_stage.sv
// Release timer for one protection stage: pick-up, operating time, start and trip.
// Operation
// - Mechanical curve: k over 0.339 minus 0.236 ratio.
// - Log curve: 5.8 minus 1.35 ln term.
// - Delayed release holds start, else drops at once.
// - Release delay in 5 ms steps, default 60 ms.
// - Reset-after-release clears counter after full delay.
// - Without reset-after-release, counter clears on drop.
// - With reset-after-release, continue option keeps counter running during release.
// - Default options freeze counter during release delay.
// - Delayed release, no reset-after: counter clears immediately.
// - No trip unless pick-up returns within delay.
// - Forcing enable lets user set stage status.
// - Measured currents still drive stage while forcing.
// - Force codes 1..4; ignored unless forcing enabled.
// All inputs come from logic on clk; the settings may change at any time.
`timescale 1ns/1ns

module psrt_stage #(
  parameter int W           = 16,
  parameter int TW          = 24,
  parameter int TICK_CYCLES = psrt_pkg::TICK_CYCLES
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic [W-1:0]            measured_max_current,
  input  wire logic [W-1:0]            pickup_setting,
  input  wire logic [W-1:0]            time_dial_milli,
  input  wire psrt_pkg::psrt_curve_t   curve_sel,
  input  wire psrt_pkg::psrt_cfg_t     cfg,
  input  wire logic                    block_in,
  input  wire logic                    force_enable,
  input  wire psrt_pkg::psrt_force_t   force_status,
  output psrt_pkg::psrt_out_t          stage_out_r,
  output logic [TW-1:0]                op_time_ms_r
);
  import psrt_pkg::*;

  logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_r;
  logic                           tick_r;
  logic [TW-1:0]                  delay_ms;
  logic [TW-1:0]                  delay_ms_r;
  logic [TW-1:0]                  rel_cnt_r;
  logic [TW-1:0]                  release_ms;
  psrt_state_t                    state_r;
  psrt_state_t                    state_nxt;
  logic                           f_start;
  logic                           f_trip;
  logic                           f_block;
  logic                           blocked;
  logic                           pick_eff;
  logic                           rel_done;

  ////////////////////////////////////////////////////////////////////////////////

  psrt_curve #(.W(W), .TW(TW)) u_curve (
    .measured_max_current (measured_max_current),
    .pickup_setting       (pickup_setting),
    .time_dial_milli      (time_dial_milli),
    .sel                  (curve_sel),
    .delay_ms             (delay_ms)
  );

  // Registering the curve result cuts the long divider path from the trip compare.
  always_ff @(posedge clk or posedge rst)
    if (rst)
      delay_ms_r <= '1;
    else
      delay_ms_r <= delay_ms;

  // One pulse per millisecond paces both counters.
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end
    else
    begin
      tick_r     <= (tick_cnt_r == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));
      tick_cnt_r <= (tick_cnt_r == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)) ? '0
                  : tick_cnt_r + 1'b1;
    end

  ////////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    // Force codes act only while forcing is enabled; measurement keeps acting too.
    f_start    = force_enable && (force_status == FORCE_START);
    f_trip     = force_enable && (force_status == FORCE_TRIP);
    f_block    = force_enable && (force_status == FORCE_BLOCKED);
    blocked    = block_in || f_block;
    pick_eff   = (measured_max_current >= pickup_setting) && (pickup_setting != '0)
              && !blocked;
    release_ms = TW'(cfg.release_steps * 20'(RELEASE_STEP_MS));
    rel_done   = (rel_cnt_r >= release_ms);
  end

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (pick_eff)
          state_nxt = ST_RUN;
      ST_RUN:
        if (!pick_eff)
          state_nxt = (cfg.delayed_release || cfg.op_reset_after_release) ? ST_HOLD
                    : ST_IDLE;
      ST_HOLD:
        if (pick_eff)
          state_nxt = ST_RUN;
        else if (rel_done)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
    if (rst)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;

  // Release timer counts milliseconds of pick-up absence.
  always_ff @(posedge clk or posedge rst)
    if (rst)
      rel_cnt_r <= '0;
    else if (state_r != ST_HOLD || pick_eff)
      rel_cnt_r <= '0;
    else if (tick_r && !rel_done)
      rel_cnt_r <= rel_cnt_r + 1'b1;

  // Operating time counter, saturating so a long fault cannot wrap it to zero.
  always_ff @(posedge clk or posedge rst)
    if (rst)
      op_time_ms_r <= '0;
    else if (state_nxt == ST_IDLE)
      op_time_ms_r <= '0;
    else if (state_r == ST_RUN && state_nxt == ST_HOLD && !cfg.op_reset_after_release)
      op_time_ms_r <= '0;
    else if (tick_r && op_time_ms_r != '1
             && (state_nxt == ST_RUN
                 || (state_r == ST_HOLD && cfg.continue_timing
                     && cfg.op_reset_after_release)))
      op_time_ms_r <= op_time_ms_r + 1'b1;

  always_ff @(posedge clk or posedge rst)
    if (rst)
      stage_out_r <= '0;
    else
    begin
      stage_out_r.start   <= pick_eff || f_start || f_trip
                          || (cfg.delayed_release && state_nxt == ST_HOLD);
      // A running counter during release cannot trip until pick-up returns.
      stage_out_r.trip    <= (pick_eff && op_time_ms_r >= delay_ms_r) || f_trip;
      stage_out_r.blocked <= blocked;
    end

  ////////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_drop;
    state_r == ST_RUN && !pick_eff;
  endsequence

  sequence s_holding;
    state_r == ST_HOLD && state_nxt == ST_HOLD;
  endsequence

  a_start_instant_drop: assert property (
    (!cfg.delayed_release && !pick_eff && !f_start && !f_trip) |=> !stage_out_r.start)
    else $error("start held without delayed release");

  a_start_held_release: assert property (
    (state_r == ST_HOLD && $past(cfg.delayed_release) && !$past(state_r == ST_RUN))
      |-> stage_out_r.start)
    else $error("start dropped during release delay");

  // The bound is the previous delay, since the setting may shrink in mid-release.
  a_release_bound: assert property (
    (state_r == ST_HOLD) |-> (rel_cnt_r <= $past(release_ms)))
    else $error("release timer overran the delay");

  a_clear_after_rel: assert property (
    (state_r == ST_HOLD && state_nxt == ST_IDLE) |=> (op_time_ms_r == '0 && state_r == ST_IDLE))
    else $error("counter not cleared at end of release");

  a_clear_on_drop: assert property (
    (s_drop and (!cfg.op_reset_after_release)) |=> (op_time_ms_r == '0))
    else $error("counter not cleared on pick-up drop");

  a_continue_counts: assert property (
    (s_holding and (cfg.continue_timing && cfg.op_reset_after_release && tick_r
                    && op_time_ms_r != '1))
      |=> (op_time_ms_r == $past(op_time_ms_r) + 1'b1))
    else $error("counter did not advance during release");

  a_hold_freezes: assert property (
    (s_holding and (!cfg.continue_timing)) |=> $stable(op_time_ms_r))
    else $error("counter moved during frozen release");

  a_trip_cause: assert property (
    (stage_out_r.trip && !$past(f_trip))
      |-> $past(pick_eff && op_time_ms_r >= delay_ms_r))
    else $error("trip without pick-up and elapsed delay");

  a_force_trip: assert property (
    (f_trip ##1 f_trip) |-> (stage_out_r.trip && stage_out_r.start))
    else $error("forced trip not shown");

  a_force_gated: assert property (
    (!force_enable && !block_in) |=> !stage_out_r.blocked)
    else $error("blocked shown with forcing disabled");

  a_measure_forced: assert property (
    (force_enable && pick_eff) |=> stage_out_r.start)
    else $error("measurement ignored while forcing");
endmodule

// File: testbench.sv
// Self-checking testbench for the protection stage release timer.
// Assumes psrt_pkg and psrt_stage are compiled first; the bench drives every input port itself.
`timescale 1ns/1ns

module testbench;
  import psrt_pkg::*;

  typedef struct packed
  {
    logic        fe;
    psrt_force_t fs;
    logic        blk;
    logic [15:0] im;
    psrt_out_t   exp;
  } psrt_row_t;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] measured_max_current = 16'h0000;
  logic [15:0] pickup_setting = 16'h0064;
  logic [15:0] time_dial_milli = 16'h03e8;
  psrt_curve_t curve_sel = CURVE_MECH;
  psrt_cfg_t   cfg = psrt_cfg_t'({3'b110, 16'h0002});
  logic        block_in = 1'b0;
  logic        force_enable = 1'b0;
  psrt_force_t force_status = FORCE_NORMAL;
  psrt_out_t   stage_out_r;
  logic [23:0] op_time_ms_r;
  logic [23:0] held;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          cyc = 0;

  // Rows: forcing enable, forced status, block, current, expected {start,trip,blocked}.
  psrt_row_t rows [7] = '{
    '{1'b0, FORCE_TRIP,    1'b0, 16'h0000, 3'b000},
    '{1'b1, FORCE_NORMAL,  1'b0, 16'h0000, 3'b000},
    '{1'b1, FORCE_START,   1'b0, 16'h0000, 3'b100},
    '{1'b1, FORCE_TRIP,    1'b0, 16'h0000, 3'b110},
    '{1'b1, FORCE_BLOCKED, 1'b0, 16'h00c8, 3'b001},
    '{1'b0, FORCE_NORMAL,  1'b1, 16'h0000, 3'b001},
    '{1'b1, FORCE_NORMAL,  1'b0, 16'h00c8, 3'b100}
  };

  psrt_stage #(.TICK_CYCLES(4)) i_dut (
    .clk                  (clk),
    .rst                  (rst),
    .measured_max_current (measured_max_current),
    .pickup_setting       (pickup_setting),
    .time_dial_milli      (time_dial_milli),
    .curve_sel            (curve_sel),
    .cfg                  (cfg),
    .block_in             (block_in),
    .force_enable         (force_enable),
    .force_status         (force_status),
    .stage_out_r          (stage_out_r),
    .op_time_ms_r         (op_time_ms_r)
  );

  always #10 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////

  task automatic close_out;
    $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // A hung wait must not stall the run forever.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic chk(input string name, input logic [23:0] e, input logic [23:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, e, g);
    end
  endtask

  task automatic chk_rng(input string name, input logic [23:0] lo, hi, g);
    n_compared++;
    // An unknown seen value fails as well, since the range test then yields no 1.
    if ((g >= lo && g <= hi) !== 1'b1)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", name, lo, hi, g);
    end
  endtask

  // Inputs always change 1 ns after a rising edge, never on it.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_op(input logic [23:0] n);
    int i;
    i = 0;
    while (op_time_ms_r < n && i < 4000)
    begin
      step(1);
      i++;
    end
    chk_rng("op time reached", n, 24'hffffff, op_time_ms_r);
  endtask

  task automatic curve_run(input psrt_curve_t c, input logic [15:0] im, input logic [23:0] lo, hi);
    int i;
    curve_sel = c;
    measured_max_current = im;
    i = 0;
    while (stage_out_r.trip !== 1'b1 && i < 6000)
    begin
      step(1);
      i++;
    end
    chk_rng("trip time", lo, hi, op_time_ms_r);
    measured_max_current = 16'h0000;
    step(60);
  endtask

  task automatic drop_case(input logic [2:0] opt, input logic exp_start, input logic [23:0] e_op);
    cfg = psrt_cfg_t'({opt, 16'h0002});
    measured_max_current = 16'h00c8;
    wait_op(24'h3);
    measured_max_current = 16'h0000;
    step(2);
    chk("start after drop", 24'(exp_start), 24'(stage_out_r.start));
    chk("op time after drop", e_op, op_time_ms_r);
    step(60);
    $display("test drop case %b done", opt);
  endtask

  ////////////////////////////////////////////////////////////////////////////////

  initial
  begin
    step(16);
    chk("outputs in reset", 24'h0, {stage_out_r, op_time_ms_r[20:0]});
    $display("test reset done");
    rst = 1'b0;
    step(2);
    foreach (rows[i])
    begin
      force_enable = rows[i].fe;
      force_status = rows[i].fs;
      block_in = rows[i].blk;
      measured_max_current = rows[i].im;
      step(2);
      chk("stage outputs", 24'(rows[i].exp), 24'(stage_out_r));
      force_enable = 1'b0;
      block_in = 1'b0;
      measured_max_current = 16'h0000;
      step(60);
    end
    $display("test forcing rows done");
    // Ratio 0.5 with dial 0.05 gives 226 ms; ratio 64 with dial 1.0 gives 190 ms.
    time_dial_milli = 16'h0032;
    curve_run(CURVE_MECH, 16'h00c8, 24'd224, 24'd228);
    time_dial_milli = 16'h03e8;
    curve_run(CURVE_LOG, 16'h1900, 24'd180, 24'd192);
    curve_sel = CURVE_MECH;
    $display("test curves done");
    // Default options, release delay 10 ms: counter frozen, resumes when pick-up returns.
    measured_max_current = 16'h00c8;
    wait_op(24'h5);
    measured_max_current = 16'h0000;
    held = op_time_ms_r;
    step(30);
    chk("held start", 24'h1, 24'(stage_out_r.start));
    chk("frozen op time", held, op_time_ms_r);
    measured_max_current = 16'h00c8;
    step(2);
    chk_rng("resumed op time", held, held + 24'h1, op_time_ms_r);
    measured_max_current = 16'h0000;
    step(55);
    chk("released start", 24'h0, 24'(stage_out_r.start));
    chk("cleared op time", 24'h0, op_time_ms_r);
    $display("test default release done");
    // Without delayed release the start drops at once, whether or not the counter is kept.
    drop_case(3'b100, 1'b1, 24'h0);
    drop_case(3'b000, 1'b0, 24'h0);
    drop_case(3'b010, 1'b0, 24'h3);
    // Tiny dial makes the 4 ms delay pass while the counter runs on during release.
    cfg = psrt_cfg_t'({3'b111, 16'h0002});
    time_dial_milli = 16'h0001;
    measured_max_current = 16'h00c8;
    wait_op(24'h2);
    measured_max_current = 16'h0000;
    held = op_time_ms_r;
    step(30);
    chk_rng("continued op time", held + 24'h5, held + 24'h8, op_time_ms_r);
    chk("no trip in release", 24'h0, 24'(stage_out_r.trip));
    step(60);
    $display("test continue timing done");
    time_dial_milli = 16'h03e8;
    measured_max_current = 16'h00c8;
    wait_op(24'h3);
    rst = 1'b1;
    step(1);
    chk("outputs in mid reset", 24'h0, {stage_out_r, op_time_ms_r[20:0]});
    rst = 1'b0;
    step(1);
    // Pick-up is still present: start returns at once, the reset delay register keeps trip off.
    chk("outputs after reset", 24'h800000, {stage_out_r, op_time_ms_r[20:0]});
    $display("test mid-run reset done");
    close_out();
  end
endmodule
